// ---- rx_port_csi_error_and_frame_ctl.sv ----
`timescale 1ns/1ps
module rx_port_csi_error_and_frame_ctl
  import rx_port_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register access, already decoded from I2C
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Packet check events, one per port, one-cycle pulses except RX_LOCK, which is a level
  input wire logic [1:0] PKT_END,
  input wire logic [1:0] LENGTH_MISMATCH,
  input wire logic [1:0] CHECKSUM_FAIL,
  input wire logic [1:0] HEADER_MULTIBIT,
  input wire logic [1:0] HEADER_SINGLEBIT,
  input wire logic [1:0] PARITY_FAULT,
  input wire logic [1:0] LINE_SIZE_CHANGE,
  input wire logic [1:0] FRAME_SIZE_CHANGE,
  input wire logic [1:0] RX_LOCK,
  input wire logic [1:0] FRAME_END_GOOD,
  // Header correction path, port 0 and port 1
  input wire logic [31:0] HEADER_IN_0,
  input wire logic [31:0] HEADER_IN_1,
  input wire logic [31:0] SYNDROME_FIX_0,
  input wire logic [31:0] SYNDROME_FIX_1,
  output logic [31:0] HEADER_OUT_0,
  output logic [31:0] HEADER_OUT_1,
  // Raw mode sync inputs of the stream port (port 0)
  input wire logic RAW_LINE_VALID,
  input wire logic RAW_FRAME_VALID,
  output logic LINE_ACTIVE,
  output logic FRAME_ACTIVE,
  // Pixel stream of port 0
  input wire logic PIX_VALID,
  output logic PIX_READY,
  input wire logic [9:0] PIX_DATA,
  input wire logic PIX_LAST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [9:0] OUT_DATA,
  output logic OUT_LAST,
  output logic [1:0] PORT_PASS,
  output logic RAW_PACK_EIGHT
);
  import rx_port_pkg::*;

  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic e);
    if (e && v != COUNT_MAX) sat_inc = v + 8'h01;
    else sat_inc = v;
  endfunction

  function automatic logic [1:0] ptr_inc(input logic [1:0] v);
    ptr_inc = (v == 2'h3) ? v : v + 2'h1;
  endfunction

  logic [7:0] port_select;
  logic [7:0] flags [NUM_PORTS];
  logic [7:0] err_count [NUM_PORTS];
  logic [7:0] video_cfg [NUM_PORTS];
  logic [7:0] qual_ctl [NUM_PORTS];
  logic [1:0] good_frames [NUM_PORTS];
  fwd_state_t fwd_state [NUM_PORTS];
  fwd_state_t next_fwd_state [NUM_PORTS];

  wire sel0 = port_select[0];
  wire sel1 = port_select[1];
  wire [1:0] port_hit = {sel1, sel0}; // see R1
  wire wr_select = REG_WR && (REG_ADDR == PORT_SELECT_ADDR);
  wire rd_flags = REG_RD && (REG_ADDR == ERROR_FLAGS_ADDR);
  wire rd_count = REG_RD && (REG_ADDR == ERROR_COUNT_ADDR);
  wire wr_cfg = REG_WR && (REG_ADDR == VIDEO_CONFIG_ADDR);
  wire wr_qual = REG_WR && (REG_ADDR == QUALIFY_CONTROL_ADDR);
  // Lowest selected port answers reads
  wire rd_port = sel0 ? 1'b0 : 1'b1;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) port_select <= PORT_SELECT_RESET;
    else if (wr_select) port_select <= REG_WDATA;
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (REG_ADDR)
      PORT_SELECT_ADDR: rd_mux = port_select;
      ERROR_FLAGS_ADDR: rd_mux = flags[rd_port];
      ERROR_COUNT_ADDR: rd_mux = err_count[rd_port];
      VIDEO_CONFIG_ADDR: rd_mux = video_cfg[rd_port];
      QUALIFY_CONTROL_ADDR: rd_mux = qual_ctl[rd_port];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) REG_RDATA <= 8'h00;
    else if (REG_RD && (port_select[1:0] != 2'b00)) REG_RDATA <= rd_mux;
    else if (REG_RD) REG_RDATA <= 8'h00;
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      wire [3:0] events = {LENGTH_MISMATCH[p], CHECKSUM_FAIL[p],
                           HEADER_MULTIBIT[p], HEADER_SINGLEBIT[p]};
      wire clr_flags = rd_flags && port_hit[p] && (rd_port == 1'(p));
      wire clr_count = rd_count && port_hit[p] && (rd_port == 1'(p));
      wire pkt_bad = PKT_END[p] && (|events);
      wire [3:0] kept = clr_flags ? 4'h0 : flags[p][3:0];
      wire [7:0] count_base = clr_count ? 8'h00 : err_count[p];
      wire parity_cut = PARITY_FAULT[p] && video_cfg[p][PARITY_DISCARD_BIT];
      wire line_cut = LINE_SIZE_CHANGE[p] && video_cfg[p][LINE_DISCARD_BIT];
      wire frame_cut = FRAME_SIZE_CHANGE[p] &&
                       video_cfg[p][FRAME_DISCARD_BIT];
      wire [1:0] threshold = qual_ctl[p][1:0];
      wire thr_met = (threshold == 2'h0) ? RX_LOCK[p] :
                     (good_frames[p] >= threshold); // see R13

      always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          flags[p] <= 8'h00;
          err_count[p] <= 8'h00;
        end else begin
          // Set wins over the clearing read
          flags[p] <= {4'h0, kept | events}; // see R2 R3 R4 R5 R17
          err_count[p] <= sat_inc(count_base, pkt_bad); // see R6 R16
        end
      end

      always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          video_cfg[p] <= VIDEO_CONFIG_RESET;
          qual_ctl[p] <= QUALIFY_CONTROL_RESET;
        end else begin
          if (wr_cfg && port_hit[p]) video_cfg[p] <= REG_WDATA;
          if (wr_qual && port_hit[p]) qual_ctl[p] <= REG_WDATA;
        end
      end

      always_comb begin
        next_fwd_state[p] = fwd_state[p];
        case (fwd_state[p])
          ST_WAIT: if (thr_met) next_fwd_state[p] = ST_PASS;
          // see R9 R10 R11
          ST_PASS: if (parity_cut || line_cut || frame_cut)
            next_fwd_state[p] = ST_DROP;
          ST_DROP: next_fwd_state[p] = ST_WAIT; // see R12
          default: next_fwd_state[p] = ST_WAIT;
        endcase
        if (!RX_LOCK[p]) next_fwd_state[p] = ST_WAIT;
      end

      always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          fwd_state[p] <= ST_WAIT;
          good_frames[p] <= 2'h0;
        end else begin
          fwd_state[p] <= next_fwd_state[p];
          if (next_fwd_state[p] == ST_DROP || !RX_LOCK[p])
            good_frames[p] <= 2'h0; // see R12
          else if (FRAME_END_GOOD[p] && fwd_state[p] == ST_WAIT)
            good_frames[p] <= ptr_inc(good_frames[p]);
        end
      end

      assign PORT_PASS[p] = (fwd_state[p] == ST_PASS);
    end
  endgenerate

  // Single-bit errors fixed by flipping the syndrome-indicated bit
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HEADER_OUT_0 <= 32'h0000_0000;
      HEADER_OUT_1 <= 32'h0000_0000;
    end else begin
      HEADER_OUT_0 <= HEADER_SINGLEBIT[0] ? HEADER_IN_0 ^ SYNDROME_FIX_0
                                          : HEADER_IN_0; // see R4 R5
      HEADER_OUT_1 <= HEADER_SINGLEBIT[1] ? HEADER_IN_1 ^ SYNDROME_FIX_1
                                          : HEADER_IN_1; // see R4 R5
    end
  end

  // Raw-mode sync polarity
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LINE_ACTIVE <= 1'b0;
      FRAME_ACTIVE <= 1'b0;
    end else begin
      LINE_ACTIVE <= RAW_LINE_VALID ^ video_cfg[0][LV_POL_BIT]; // see R14
      FRAME_ACTIVE <= RAW_FRAME_VALID ^ video_cfg[0][FV_POL_BIT]; // see R15
    end
  end

  // Stream of port 0: packing select and truncation gate
  wire [1:0] pack_sel = video_cfg[0][PACK_HI:PACK_LO];
  wire [9:0] packed_data = (pack_sel == PACK_UPPER) ? {2'b00, PIX_DATA[9:2]} :
                           (pack_sel == PACK_LOWER) ? {2'b00, PIX_DATA[7:0]} :
                           PIX_DATA; // see R7
  wire forward = PORT_PASS[0];
  wire buf_in_ready;
  // Dropped words are consumed but not written to the buffer
  assign PIX_READY = forward ? buf_in_ready : 1'b1;
  assign RAW_PACK_EIGHT = pack_sel[1]; // see R7

  rx_skid_buffer u_buf (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_valid(PIX_VALID && forward),
    .in_ready(buf_in_ready),
    .in_data(packed_data),
    .in_last(PIX_LAST),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(OUT_DATA),
    .out_last(OUT_LAST)
  );
endmodule

// ---- rx_port_pkg.sv ----
// How it works
// R1: Register accesses go to the receive port chosen by the port-select value.
// R2: Length mismatch sets sticky bit 3; reading the status clears it.
// R3: Payload checksum failure sets sticky bit 2; cleared on status read.
// R4: Multi-bit header error sets sticky bit 1, header left as is.
// R5: Single-bit header errors are corrected and set sticky bit 0.
// R6: Eight-bit count of errored packets since last read; read clears it.
// R7: Raw10 packing: 00 normal, 01 reserved, 10 upper byte, 11 lower byte.
// R8: Software choosing 8-bit packing must also update the raw10 data type.
// R9: Parity-discard bit (set at reset) truncates frame on link parity error.
// R10: Line-size discard bit truncates frame when line size changes.
// R11: Frame-size discard bit truncates frame when lines per frame change.
// R12: After frame-size truncation, forwarding waits for the pass threshold.
// R13: Threshold zero passes at lock; else after that many valid frames.
// R14: Raw mode line-valid is active low when bit 1 is set.
// R15: Raw mode frame-valid is active low when bit 0 is set.
// R16: Error counter saturates; error during clearing read counts afterwards.
// R17: Error coinciding with a clearing status read leaves its flag set.
package rx_port_pkg;
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] ERROR_FLAGS_ADDR = 8'h7A;
  localparam logic [7:0] ERROR_COUNT_ADDR = 8'h7B;
  localparam logic [7:0] VIDEO_CONFIG_ADDR = 8'h7C;
  localparam logic [7:0] QUALIFY_CONTROL_ADDR = 8'h7D;
  localparam logic [7:0] VIDEO_CONFIG_RESET = 8'h20;
  localparam logic [7:0] QUALIFY_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_SELECT_RESET = 8'h01;
  localparam int LENGTH_ERR_BIT = 3;
  localparam int CHECKSUM_FLAG_BIT = 2;
  localparam int MULTIBIT_ERR_BIT = 1;
  localparam int SINGLEBIT_ERR_BIT = 0;
  localparam int PACK_HI = 7;
  localparam int PACK_LO = 6;
  localparam int PARITY_DISCARD_BIT = 5;
  localparam int LINE_DISCARD_BIT = 4;
  localparam int FRAME_DISCARD_BIT = 3;
  localparam int LV_POL_BIT = 1;
  localparam int FV_POL_BIT = 0;
  localparam logic [1:0] PACK_NORMAL = 2'h0;
  localparam logic [1:0] PACK_UPPER = 2'h2;
  localparam logic [1:0] PACK_LOWER = 2'h3;
  localparam int NUM_PORTS = 2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_PASS = 3'b010,
    ST_DROP = 3'b100
  } fwd_state_t;
endpackage

// ---- rx_skid_buffer.sv ----
`timescale 1ns/1ps
module rx_skid_buffer (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [9:0] in_data,
  input wire logic in_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_data,
  output logic out_last
);
  logic [10:0] slot [2];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot[rd_ptr][9:0];
  assign out_last = slot[rd_ptr][10];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      slot[0] <= 11'h000;
      slot[1] <= 11'h000;
    end else begin
      if (push) begin
        slot[wr_ptr] <= {in_last, in_data};
        wr_ptr <= ~wr_ptr;
      end
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- rx_port_props.sv ----
`timescale 1ns/1ps
module rx_port_props
  import rx_port_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [1:0] PARITY_FAULT,
  input wire logic [1:0] FRAME_SIZE_CHANGE,
  input wire logic RAW_LINE_VALID,
  input wire logic RAW_FRAME_VALID,
  input wire logic LINE_ACTIVE,
  input wire logic FRAME_ACTIVE,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [9:0] OUT_DATA,
  input wire logic [1:0] PORT_PASS,
  input wire logic RAW_PACK_EIGHT
);
  logic [7:0] sel;
  logic [7:0] cfg;
  // Shadow of port select and port 0 config
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sel <= PORT_SELECT_RESET;
      cfg <= VIDEO_CONFIG_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == PORT_SELECT_ADDR) sel <= REG_WDATA;
      if (REG_ADDR == VIDEO_CONFIG_ADDR && sel[0]) cfg <= REG_WDATA;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_dropped;
    !PORT_PASS[0] ##1 !PORT_PASS[0];
  endsequence
  property p_unmapped;
    REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00;
  endproperty
  property p_cfg_read;
    REG_RD && REG_ADDR == VIDEO_CONFIG_ADDR && sel[0]
      |=> REG_RDATA == $past(cfg);
  endproperty
  property p_pack;
    RAW_PACK_EIGHT == cfg[PACK_HI];
  endproperty
  property p_line;
    1 |=> LINE_ACTIVE == ($past(RAW_LINE_VALID) ^ $past(cfg[LV_POL_BIT]));
  endproperty
  property p_frame_act;
    1 |=> FRAME_ACTIVE == ($past(RAW_FRAME_VALID) ^ $past(cfg[FV_POL_BIT]));
  endproperty
  property p_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
  endproperty
  property p_parity;
    PORT_PASS[0] && PARITY_FAULT[0] && cfg[PARITY_DISCARD_BIT] |=> s_dropped;
  endproperty
  property p_frame;
    PORT_PASS[0] && FRAME_SIZE_CHANGE[0] && cfg[FRAME_DISCARD_BIT]
      |=> s_dropped;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_cfg_read: assert property (p_cfg_read)
    else $error("config readback");
  a_pack: assert property (p_pack)
    else $error("packing select");
  a_line: assert property (p_line)
    else $error("line polarity");
  a_frame_act: assert property (p_frame_act)
    else $error("frame polarity");
  a_hold: assert property (p_hold)
    else $error("stalled output changed");
  a_parity: assert property (p_parity)
    else $error("parity truncation");
  a_frame: assert property (p_frame)
    else $error("frame size truncation");
endmodule

// ---- rx_port_serializer_model.sv ----
`timescale 1ns/1ps
module rx_port_serializer_model (
  input wire logic clk,
  input wire logic ready,
  output logic [1:0] pkt_end,
  output logic [7:0] err,
  output logic valid,
  output logic [9:0] data,
  output logic last
);
  initial begin
    pkt_end = 2'h0;
    err = 8'h00;
    valid = 1'b0;
    data = 10'h3FF;
    last = 1'b0;
  end
  task automatic send_pkt(input logic [1:0] port, input logic [7:0] e);
    @(posedge clk);
    pkt_end <= port;
    err <= e;
    @(posedge clk);
    pkt_end <= 2'h0;
    err <= 8'h00;
  endtask
  // Word held until taken; released bus shows inverse
  task automatic send_words(input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      valid <= 1'b1;
      data <= 10'(i * 97 + 5);
      last <= (i == n - 1);
      do @(negedge clk); while (!ready);
      @(posedge clk);
    end
    valid <= 1'b0;
    data <= ~data;
  endtask
endmodule

// ---- rx_port_csi_error_and_frame_ctl_test.sv ----
`timescale 1ns/1ps
module rx_port_csi_error_and_frame_ctl_test
  import rx_port_pkg::*;
;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
  int mismatches = 0;
  int check_count = 0;
  int got = 0;
  int pk = 0;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA, err;
  logic [1:0] PKT_END, PORT_PASS, PARITY_FAULT = 2'h0, RX_LOCK = 2'h3;
  logic [1:0] LINE_SIZE_CHANGE = 2'h0, FRAME_SIZE_CHANGE = 2'h0;
  logic [1:0] FRAME_END_GOOD = 2'h0;
  logic RAW_LINE_VALID = 1'b0, RAW_FRAME_VALID = 1'b1, OUT_READY = 1'b1;
  logic LINE_ACTIVE, FRAME_ACTIVE, PIX_VALID, PIX_READY, PIX_LAST;
  logic OUT_VALID, RAW_PACK_EIGHT, OUT_LAST;
  logic [31:0] HDR_IN = 32'h1234_5678, HDR_FIX = 32'h0000_0100;
  logic [31:0] HDR_OUT0, HDR_OUT1;
  logic [9:0] PIX_DATA, OUT_DATA;
  always #20 MCLK = ~MCLK;
  rx_port_csi_error_and_frame_ctl dut_u (.MCLK, .SYS_RST, .REG_WR, .REG_RD,
    .REG_ADDR, .REG_WDATA, .REG_RDATA, .PKT_END, .LENGTH_MISMATCH(err[7:6]),
    .CHECKSUM_FAIL(err[5:4]), .HEADER_MULTIBIT(err[3:2]),
    .HEADER_SINGLEBIT(err[1:0]), .PARITY_FAULT, .LINE_SIZE_CHANGE,
    .FRAME_SIZE_CHANGE, .RX_LOCK, .FRAME_END_GOOD,
    .HEADER_IN_0(HDR_IN), .HEADER_IN_1(HDR_IN), .SYNDROME_FIX_0(HDR_FIX),
    .SYNDROME_FIX_1(HDR_FIX), .HEADER_OUT_0(HDR_OUT0),
    .HEADER_OUT_1(HDR_OUT1), .RAW_LINE_VALID, .RAW_FRAME_VALID,
    .LINE_ACTIVE, .FRAME_ACTIVE, .PIX_VALID, .PIX_READY, .PIX_DATA,
    .PIX_LAST, .OUT_VALID, .OUT_READY, .OUT_DATA, .OUT_LAST, .PORT_PASS,
    .RAW_PACK_EIGHT);
  rx_port_serializer_model ser_u (.clk(MCLK), .ready(PIX_READY),
    .pkt_end(PKT_END), .err(err), .valid(PIX_VALID), .data(PIX_DATA),
    .last(PIX_LAST));
  function automatic logic [9:0] ew(int i);
    logic [9:0] w;
    w = 10'(i * 97 + 5);
    return pk == 2 ? w >> 2 : pk == 3 ? {2'b00, w[7:0]} : w;
  endfunction
  always @(negedge MCLK) begin
    if (OUT_VALID && OUT_READY) begin
      `CHK("word", ew(got % 4), OUT_DATA)
      `CHK("last", (got % 4 == 3), OUT_LAST)
      got++;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    `CHK("rdata", e, REG_RDATA)
  endtask
  task automatic pass_after(input int n, input logic e);
    repeat (n) @(negedge MCLK);
    `CHK("pass", e, PORT_PASS[0])
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400_000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rchk(VIDEO_CONFIG_ADDR, VIDEO_CONFIG_RESET);
    rchk(PORT_SELECT_ADDR, PORT_SELECT_RESET);
    rchk(8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      ser_u.send_pkt(2'b01, 8'h01 << (2 * k));
      @(negedge MCLK);
      `CHK("hdr0", k ? HDR_IN : HDR_IN ^ HDR_FIX, HDR_OUT0)
      `CHK("hdr1", HDR_IN, HDR_OUT1)
      rchk(ERROR_FLAGS_ADDR, 8'h01 << k);
      rchk(ERROR_FLAGS_ADDR, 8'h00);
    end
    rchk(ERROR_COUNT_ADDR, 8'h04);
    rchk(ERROR_COUNT_ADDR, 8'h00);
    wr(PORT_SELECT_ADDR, 8'h02);
    ser_u.send_pkt(2'b01, 8'h10);
    rchk(ERROR_FLAGS_ADDR, 8'h00);
    ser_u.send_pkt(2'b10, 8'h20);
    rchk(ERROR_FLAGS_ADDR, 8'h04);
    wr(PORT_SELECT_ADDR, 8'h01);
    rchk(ERROR_FLAGS_ADDR, 8'h04);
    rchk(ERROR_COUNT_ADDR, 8'h01);
    for (int j = 0; j < 2; j++) begin
      fork
        rchk(ERROR_FLAGS_ADDR + 8'(j), j ? 8'h01 : 8'h00);
        ser_u.send_pkt(2'b01, 8'h10);
      join
      rchk(ERROR_FLAGS_ADDR + 8'(j), j ? 8'h01 : 8'h04);
    end
    repeat (300) ser_u.send_pkt(2'b01, 8'h10);
    rchk(ERROR_COUNT_ADDR, COUNT_MAX);
    wr(8'h70, 8'h2A);
    for (int p = 0; p < 4; p++) begin
      pk = p;
      wr(VIDEO_CONFIG_ADDR, {2'(p), 6'h20});
      fork
        ser_u.send_words(4);
        begin
          OUT_READY <= 1'b0;
          repeat (6) @(negedge MCLK);
          `CHK("full", 1'b0, PIX_READY)
          @(posedge MCLK);
          OUT_READY <= 1'b1;
        end
      join
      repeat (4) @(posedge MCLK);
    end
    `CHK("count", 16, got)
    wr(VIDEO_CONFIG_ADDR, 8'h00);
    @(posedge MCLK) PARITY_FAULT <= 2'b01;
    @(posedge MCLK) PARITY_FAULT <= 2'b00;
    pass_after(3, 1'b1);
    wr(VIDEO_CONFIG_ADDR, VIDEO_CONFIG_RESET);
    @(posedge MCLK) PARITY_FAULT <= 2'b01;
    @(posedge MCLK) PARITY_FAULT <= 2'b00;
    pass_after(1, 1'b0);
    wr(VIDEO_CONFIG_ADDR, 8'h10);
    @(posedge MCLK) LINE_SIZE_CHANGE <= 2'b01;
    @(posedge MCLK) LINE_SIZE_CHANGE <= 2'b00;
    pass_after(1, 1'b0);
    pass_after(4, 1'b1);
    wr(VIDEO_CONFIG_ADDR, 8'h08);
    wr(QUALIFY_CONTROL_ADDR, 8'h01);
    @(posedge MCLK) FRAME_SIZE_CHANGE <= 2'b01;
    @(posedge MCLK) FRAME_SIZE_CHANGE <= 2'b00;
    pass_after(6, 1'b0);
    `CHK("pass1", 1'b1, PORT_PASS[1])
    @(posedge MCLK) FRAME_END_GOOD <= 2'b01;
    @(posedge MCLK) FRAME_END_GOOD <= 2'b00;
    pass_after(3, 1'b1);
    @(posedge MCLK) RX_LOCK <= 2'b10;
    pass_after(2, 1'b0);
    @(posedge MCLK) RX_LOCK <= 2'b11;
    wr(QUALIFY_CONTROL_ADDR, 8'h00);
    pass_after(3, 1'b1);
    wr(VIDEO_CONFIG_ADDR, 8'h03);
    repeat (3) @(negedge MCLK);
    `CHK("line", 1'b1, LINE_ACTIVE)
    `CHK("frame", 1'b0, FRAME_ACTIVE)
    wr(VIDEO_CONFIG_ADDR, 8'h00);
    RAW_LINE_VALID <= 1'b1;
    repeat (2) @(negedge MCLK);
    `CHK("line", 1'b1, LINE_ACTIVE)
    `CHK("frame", 1'b1, FRAME_ACTIVE)
    tally_and_finish();
  end
endmodule
bind rx_port_csi_error_and_frame_ctl rx_port_props props_u (.MCLK, .SYS_RST,
  .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .PARITY_FAULT,
  .FRAME_SIZE_CHANGE, .RAW_LINE_VALID, .RAW_FRAME_VALID, .LINE_ACTIVE,
  .FRAME_ACTIVE, .OUT_VALID, .OUT_READY, .OUT_DATA, .PORT_PASS,
  .RAW_PACK_EIGHT);
